// ---- hw/asrx_dev.sv ----
// Asynchronous receiver with baud generator and receive FIFO
// Function
// R1: synchronous bit rate is Fosc/(4(X+1))
// R2: divisor is 8-bit, 0 to 255
// R3: x16 sampling, shifter advances once per bit
// R4: software loads divisor and speed before enabling
// R5: runs only with sync clear, port enabled
// R6: ninth-bit enable selects 9-bit frames
// R7: reception only while continuous enable set
// R8: word completion sets flag, raises interrupt
// R9: status shows ninth bit and errors
// R10: buffer read returns low eight bits
// R11: clearing continuous enable clears receive errors; code clears overrun only, framing bit stays with its buffered word
// R12: software sets global and peripheral enables
// R13: address detect plus 9-bit gives multidrop
// R14: priority bit selects interrupt level
// R15: addressed software clears address detect
// R16: async rate Fosc/64(X+1) or Fosc/16(X+1)
// R17: divisor write restarts generator timer
// R18: three samples per bit, majority vote
// R19: address mode keeps only ninth-bit-one words
// R20: framing on low stop, overrun when full
// R21: sender frames start, LSB first, stop
`timescale 1ns/1ps
module asrx_dev (
  input wire logic clk_i,
  input wire logic rst_n_i,
  asrx_if.dev link,
  input wire logic tsc_we_i,
  input wire logic [7:0] tsc_wdata_i,
  input wire logic rsc_we_i,
  input wire logic [7:0] rsc_wdata_i,
  input wire logic baud_we_i,
  input wire logic [7:0] baud_wdata_i,
  input wire logic rbuf_rd_i,
  input wire logic receive_interrupt_enable_i,
  input wire logic receive_interrupt_priority_i,
  output logic [7:0] tsc_o,
  output logic [7:0] rsc_o,
  output logic [7:0] baud_o,
  output logic [7:0] rbuf_o,
  output logic receive_flag_o,
  output logic rx_irq_high_o,
  output logic rx_irq_low_o,
  output logic brg_tick_o
);
  typedef enum logic [1:0] {
    ASRX_IDLE = 2'b00,
    ASRX_START = 2'b01,
    ASRX_DATA = 2'b10,
    ASRX_STOP = 2'b11
  } asrx_state_e;

  logic [7:0] tsc;
  logic [7:0] rsc_ctl;
  logic [7:0] baud_divisor;
  logic [9:0] brg_cnt;
  logic brg_tick;
  logic fast;
  logic rx_q1;
  logic rx_q2;
  logic [1:0] samp;
  logic [3:0] phase;
  logic [3:0] bit_cnt;
  logic [8:0] shreg;
  logic overrun_error_flag;
  asrx_state_e state;
  logic rx_en;
  logic bit_val;
  logic decide;
  logic [8:0] word;
  logic keep;
  logic push;
  logic fifo_in_ready;
  logic [asrx_pkg::WORD_W-1:0] head;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tsc <= asrx_pkg::TSC_RESET;
    end else if (tsc_we_i) begin
      tsc <= tsc_wdata_i & asrx_pkg::TSC_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rsc_ctl <= asrx_pkg::RSC_RESET;
    end else if (rsc_we_i) begin
      rsc_ctl <= rsc_wdata_i & asrx_pkg::RSC_WMASK;
    end
  end

  // R2: full 8-bit divisor
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      baud_divisor <= asrx_pkg::BAUD_RESET;
    end else if (baud_we_i) begin
      baud_divisor <= baud_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Baud rate generator
  // ----------------------------------------------------------------
  // R16: high speed only in async mode
  assign fast = tsc[asrx_pkg::TSC_HIGH_SPEED] && !tsc[asrx_pkg::TSC_SYNC];
  assign brg_tick = brg_cnt == 10'h000;

  // R1: sync period 4(X+1)
  // R17: divisor write reloads timer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      brg_cnt <= asrx_pkg::brg_reload(asrx_pkg::BAUD_RESET, 1'b0);
    end else if (baud_we_i) begin
      brg_cnt <= asrx_pkg::brg_reload(baud_wdata_i, fast);
    end else if (brg_tick) begin
      brg_cnt <= asrx_pkg::brg_reload(baud_divisor, fast);
    end else begin
      brg_cnt <= brg_cnt - 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      brg_tick_o <= 1'b0;
    end else begin
      brg_tick_o <= brg_tick;
    end
  end

  // ----------------------------------------------------------------
  // Data recovery
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_q1 <= 1'b1;
      rx_q2 <= 1'b1;
    end else begin
      rx_q1 <= link.line;
      rx_q2 <= rx_q1;
    end
  end

  // R3: sample shifter at x16 rate
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      samp <= 2'h3;
    end else if (brg_tick) begin
      samp <= {samp[0], rx_q2};
    end
  end

  // R18: majority of phases 7, 8, 9
  assign bit_val = (samp[1] & samp[0]) | (samp[1] & rx_q2) | (samp[0] & rx_q2);
  assign decide = brg_tick && (phase == asrx_pkg::PHASE_DECIDE) && (state != ASRX_IDLE);

  // R5: async mode with port enabled
  // R7: continuous enable gates reception
  assign rx_en = rsc_ctl[asrx_pkg::RSC_PORT_EN] && !tsc[asrx_pkg::TSC_SYNC] && rsc_ctl[asrx_pkg::RSC_CONT_EN]
    && !overrun_error_flag;

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ASRX_IDLE;
      phase <= 4'h0;
      bit_cnt <= 4'h0;
      shreg <= 9'h000;
    end else if (!rx_en) begin
      state <= ASRX_IDLE;
      phase <= 4'h0;
    end else if (brg_tick) begin
      phase <= phase + 4'h1;
      case (state)
        ASRX_IDLE: begin
          phase <= 4'h1;
          if (!rx_q2) begin
            state <= ASRX_START;
          end
        end
        ASRX_START: begin
          if (decide) begin
            state <= bit_val ? ASRX_IDLE : ASRX_DATA;
            bit_cnt <= 4'h0;
          end
        end
        ASRX_DATA: begin
          // R3: one shift per bit
          if (decide) begin
            shreg <= {bit_val, shreg[8:1]};
            bit_cnt <= bit_cnt + 4'h1;
            // R6: eight or nine data bits
            if (bit_cnt == (rsc_ctl[asrx_pkg::RSC_NINE_EN] ? asrx_pkg::LAST_BIT_9 : asrx_pkg::LAST_BIT_8)) begin
              state <= ASRX_STOP;
            end
          end
        end
        ASRX_STOP: begin
          if (decide) begin
            state <= ASRX_IDLE;
          end
        end
        default: begin
          state <= ASRX_IDLE;
        end
      endcase
    end
  end

  assign word = rsc_ctl[asrx_pkg::RSC_NINE_EN] ? shreg : {1'b0, shreg[8:1]};
  // R13: address mode needs 9-bit frames
  // R15: address enable off keeps all
  // R19: drop words with ninth bit low
  assign keep = !(rsc_ctl[asrx_pkg::RSC_ADDR_EN] && rsc_ctl[asrx_pkg::RSC_NINE_EN] && !word[8]);
  assign push = decide && (state == ASRX_STOP) && keep;

  // R20: overrun when buffer full
  // R11: cleared by dropping continuous enable
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      overrun_error_flag <= 1'b0;
    end else if (!rsc_ctl[asrx_pkg::RSC_CONT_EN]) begin
      overrun_error_flag <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      overrun_error_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // R20: framing error stored with its word
  asrx_fifo #(
    .W(asrx_pkg::WORD_W),
    .D(asrx_pkg::FIFO_DEPTH)
  ) i_asrx_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({!bit_val, word}),
    .out_valid_o(receive_flag_o),
    .out_ready_i(rbuf_rd_i),
    .out_data_o(head)
  );

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  // R10: low eight bits of head word
  assign rbuf_o = head[7:0];
  // R9: ninth bit and framing error of head word, overrun from the live flag
  assign rsc_o = {rsc_ctl[7:3], head[9] & receive_flag_o, overrun_error_flag, head[8] & receive_flag_o};
  assign tsc_o = tsc | (8'h01 << asrx_pkg::TSC_SHIFT_EMPTY);
  assign baud_o = baud_divisor;

  // R8: flag raises request when enabled
  // R14: priority selects level
  assign rx_irq_high_o = receive_flag_o && receive_interrupt_enable_i && receive_interrupt_priority_i;
  assign rx_irq_low_o = receive_flag_o && receive_interrupt_enable_i && !receive_interrupt_priority_i;
endmodule : asrx_dev

// ---- shared/asrx_pkg.sv ----
// Constants, field positions and shared arithmetic of the serial receiver and its remote sender
package asrx_pkg;
  // ----------------------------------------------------------------
  // Transmit status and control fields
  // ----------------------------------------------------------------
  localparam int TSC_SYNC = 4;
  localparam int TSC_HIGH_SPEED = 2;
  localparam int TSC_SHIFT_EMPTY = 1;
  localparam logic [7:0] TSC_RESET = 8'h02;
  localparam logic [7:0] TSC_WMASK = 8'hF5;
  // ----------------------------------------------------------------
  // Receive status and control fields
  // ----------------------------------------------------------------
  localparam int RSC_PORT_EN = 7;
  localparam int RSC_NINE_EN = 6;
  localparam int RSC_SINGLE_EN = 5;
  localparam int RSC_CONT_EN = 4;
  localparam int RSC_ADDR_EN = 3;
  localparam int RSC_FRAME_ERR = 2;
  localparam int RSC_OVERRUN = 1;
  localparam int RSC_NINTH_BIT = 0;
  localparam logic [7:0] RSC_RESET = 8'h00;
  localparam logic [7:0] RSC_WMASK = 8'hF8;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Oversampling and buffering
  // ----------------------------------------------------------------
  localparam logic [3:0] PHASE_DECIDE = 4'h9;
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 10;

  // Generator reload: X for high speed async, 4(X+1)-1 otherwise
  function automatic logic [9:0] brg_reload(input logic [7:0] x, input logic fast);
    brg_reload = fast ? {2'h0, x} : {x, 2'h3};
  endfunction : brg_reload
endpackage : asrx_pkg

// ---- shared/asrx_if.sv ----
// Serial line between the remote sender and the receiver
`timescale 1ns/1ps
interface asrx_if;
  logic line;
  modport dev (input line);
  modport rmt (output line);
endinterface : asrx_if

// ---- hw/asrx_rmt.sv ----
// Remote asynchronous sender driving the serial line, and the receiver's word FIFO
`timescale 1ns/1ps
module asrx_rmt (
  input wire logic clk_i,
  input wire logic rst_n_i,
  asrx_if.rmt link,
  input wire logic [7:0] baud_divisor_i,
  input wire logic high_speed_select_i,
  input wire logic nine_bit_i,
  input wire logic send_valid_i,
  input wire logic [8:0] send_data_i,
  output logic send_ready_o
);
  typedef enum logic [1:0] {
    ASRXR_IDLE = 2'b00,
    ASRXR_START = 2'b01,
    ASRXR_DATA = 2'b10,
    ASRXR_STOP = 2'b11
  } asrxr_state_e;

  asrxr_state_e state;
  logic [9:0] tick_cnt;
  logic [3:0] phase;
  logic [3:0] bit_cnt;
  logic [8:0] shreg;
  logic nine;
  logic line;
  logic bit_end;

  assign send_ready_o = state == ASRXR_IDLE;
  assign bit_end = (tick_cnt == 10'h000) && (phase == asrx_pkg::PHASE_LAST);
  assign link.line = line;

  // ----------------------------------------------------------------
  // Bit timing, sixteen generator periods per bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 10'h000;
      phase <= 4'h0;
    end else if (state == ASRXR_IDLE) begin
      tick_cnt <= asrx_pkg::brg_reload(baud_divisor_i, high_speed_select_i);
      phase <= 4'h0;
    end else if (tick_cnt == 10'h000) begin
      tick_cnt <= asrx_pkg::brg_reload(baud_divisor_i, high_speed_select_i);
      phase <= phase + 4'h1;
    end else begin
      tick_cnt <= tick_cnt - 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // R21: start, LSB first data, optional ninth, stop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ASRXR_IDLE;
      line <= 1'b1;
      bit_cnt <= 4'h0;
      shreg <= 9'h000;
      nine <= 1'b0;
    end else begin
      case (state)
        ASRXR_IDLE: begin
          line <= 1'b1;
          if (send_valid_i) begin
            shreg <= send_data_i;
            nine <= nine_bit_i;
            line <= 1'b0;
            state <= ASRXR_START;
          end
        end
        ASRXR_START: begin
          if (bit_end) begin
            line <= shreg[0];
            shreg <= {1'b0, shreg[8:1]};
            bit_cnt <= 4'h0;
            state <= ASRXR_DATA;
          end
        end
        ASRXR_DATA: begin
          if (bit_end) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == (nine ? asrx_pkg::LAST_BIT_9 : asrx_pkg::LAST_BIT_8)) begin
              line <= 1'b1;
              state <= ASRXR_STOP;
            end else begin
              line <= shreg[0];
              shreg <= {1'b0, shreg[8:1]};
            end
          end
        end
        ASRXR_STOP: begin
          if (bit_end) begin
            state <= ASRXR_IDLE;
          end
        end
        default: begin
          state <= ASRXR_IDLE;
        end
      endcase
    end
  end
endmodule : asrx_rmt

module asrx_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : asrx_fifo

// ---- sim/asrx_props.sv ----
// Assertions on the serial line and the receiver's register ports
`timescale 1ns/1ps
module asrx_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic line,
  input wire logic tsc_we_i,
  input wire logic [7:0] tsc_wdata_i,
  input wire logic rsc_we_i,
  input wire logic [7:0] rsc_wdata_i,
  input wire logic baud_we_i,
  input wire logic [7:0] baud_wdata_i,
  input wire logic receive_interrupt_enable_i,
  input wire logic receive_interrupt_priority_i,
  input wire logic [7:0] tsc_o,
  input wire logic [7:0] rsc_o,
  input wire logic [7:0] baud_o,
  input wire logic receive_flag_o,
  input wire logic rx_irq_high_o,
  input wire logic rx_irq_low_o,
  input wire logic brg_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [10:0] gap;
  logic gap_ok;
  logic [10:0] period;
  logic tsc_we_q;
  // Spacing is only judged between two ticks with no rate write between them;
  // a speed write also voids the tick right after it, which may still use the old reload
  always_ff @(posedge clk_i) begin
    tsc_we_q <= tsc_we_i;
  end
  assign period = (tsc_o[2] && !tsc_o[4]) ? {3'h0, baud_o} + 11'h001 : {1'h0, baud_o, 2'h0} + 11'h004;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || brg_tick_o) begin
      gap <= 11'h001;
    end else begin
      gap <= gap + 11'h001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || baud_we_i || tsc_we_i || tsc_we_q) begin
      gap_ok <= 1'b0;
    end else if (brg_tick_o) begin
      gap_ok <= 1'b1;
    end
  end
  a_tick_period: assert property (brg_tick_o && gap_ok |-> gap == period)
    else $error("generator tick spacing wrong");
  a_tsc_write: assert property (tsc_we_i |=> tsc_o == (($past(tsc_wdata_i) & 8'hF5) | 8'h02))
    else $error("transmit status write wrong");
  a_rsc_write: assert property (rsc_we_i |=> rsc_o[7:3] == $past(rsc_wdata_i[7:3]))
    else $error("receive control write wrong");
  a_baud_write: assert property (baud_we_i |=> baud_o == $past(baud_wdata_i))
    else $error("divisor write wrong");
  a_error_clear: assert property (rsc_we_i && !rsc_wdata_i[4] |-> ##2 !rsc_o[1])
    else $error("overrun kept after enable cleared");
  a_irq_high: assert property (rx_irq_high_o == (receive_flag_o && receive_interrupt_enable_i && receive_interrupt_priority_i))
    else $error("high priority request wrong");
  a_irq_low: assert property (rx_irq_low_o == (receive_flag_o && receive_interrupt_enable_i && !receive_interrupt_priority_i))
    else $error("low priority request wrong");
  a_start_bit: assert property ($fell(line) |-> !line [*8])
    else $error("start bit too short");
  a_empty_status: assert property (!receive_flag_o |-> !rsc_o[2] && !rsc_o[0])
    else $error("status bits set with empty buffer");
  a_rx_enabled: assert property ($rose(receive_flag_o) |-> $past(rsc_o[7]) && $past(rsc_o[4]))
    else $error("word received while disabled");
endmodule : asrx_props

// ---- sim/asrx_test.sv ----
// Self-checking bench: remote sender and receiver joined on one line
`timescale 1ns/1ps
module asrx_test;
  logic clk_i, rst_n_i, tsc_we_i, rsc_we_i, baud_we_i, rbuf_rd_i;
  logic [7:0] tsc_wdata_i, rsc_wdata_i, baud_wdata_i, tsc_o, rsc_o, baud_o, rbuf_o, rsc2, rbuf2;
  logic receive_interrupt_enable_i, receive_interrupt_priority_i, receive_flag_o, rx_irq_high_o, rx_irq_low_o;
  logic brg_tick_o, flag2, nine_bit_i, send_valid_i, send_ready_o;
  logic [8:0] send_data_i;
  int mismatches, total_checks;
  asrx_if lnk ();
  asrx_if lnk2 ();
  asrx_dev i_asrx_dev (.link(lnk), .*);
  // Second receiver fed by hand-made frames for line faults
  asrx_dev i_asrx_dev_b (.link(lnk2), .tsc_o(), .rsc_o(rsc2), .baud_o(), .rbuf_o(rbuf2), .receive_flag_o(flag2),
    .rx_irq_high_o(), .rx_irq_low_o(), .brg_tick_o(), .*);
  asrx_rmt i_asrx_rmt (.link(lnk), .baud_divisor_i(baud_o), .high_speed_select_i(tsc_o[2]), .*);
  asrx_props i_asrx_props (.line(lnk.line), .*);
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #10;
  endtask : tick
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input int r, input logic [7:0] d);
    tsc_we_i = (r == 0);
    rsc_we_i = (r == 1);
    baud_we_i = (r == 2);
    tsc_wdata_i = d;
    rsc_wdata_i = d;
    baud_wdata_i = d;
    tick();
    tsc_we_i = 1'b0;
    rsc_we_i = 1'b0;
    baud_we_i = 1'b0;
    tick();
  endtask : wr
  task automatic send(input logic [8:0] d);
    while (send_ready_o !== 1'b1) tick();
    send_valid_i = 1'b1;
    send_data_i = d;
    tick();
    send_valid_i = 1'b0;
    tick();
    while (send_ready_o !== 1'b1) tick();
  endtask : send
  task automatic pop;
    rbuf_rd_i = 1'b1;
    tick();
    rbuf_rd_i = 1'b0;
    tick();
  endtask : pop
  task automatic take(input logic [8:0] d);
    for (int n = 0; n < 400 && receive_flag_o !== 1'b1; n++) tick();
    chk("flag", 9'h001, {8'h00, receive_flag_o});
    chk("ninth bit", {8'h00, d[8]}, {8'h00, rsc_o[0]});
    chk("buffer", {1'b0, d[7:0]}, {1'b0, rbuf_o});
    pop();
  endtask : take
  // Hand-made 8-bit frame at 16 clocks a bit, stop level chosen
  task automatic bang(input logic [7:0] d, input logic stop);
    lnk2.line = 1'b0;
    tick(16);
    for (int i = 0; i < 8; i++) begin
      lnk2.line = d[i];
      tick(16);
    end
    lnk2.line = stop;
    tick(16);
    lnk2.line = 1'b1;
    tick(16);
  endtask : bang
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, tsc_we_i, rsc_we_i, baud_we_i, rbuf_rd_i, send_valid_i} = 6'h00;
    {tsc_wdata_i, rsc_wdata_i, baud_wdata_i, send_data_i} = 33'h0;
    {receive_interrupt_enable_i, receive_interrupt_priority_i} = 2'h0;
    nine_bit_i = 1'b1;
    lnk2.line = 1'b1;
    tick(5);
    rst_n_i = 1'b1;
    chk("tsc reset", 9'h002, {1'b0, tsc_o});
    chk("rsc reset", 9'h000, {1'b0, rsc_o});
    chk("baud reset", 9'h000, {1'b0, baud_o});
    wr(0, 8'hFF);
    chk("tsc write", 9'h0F7, {1'b0, tsc_o});
    tick(30);
    wr(2, 8'h01);
    wr(0, 8'h00);
    chk("baud write", 9'h001, {1'b0, baud_o});
    tick(30);
    wr(0, 8'h04);
    wr(2, 8'h00);
    wr(1, 8'hFF);
    chk("rsc write", 9'h0F8, {1'b0, rsc_o});
    wr(1, 8'hD0);
    send(9'h1A5);
    send(9'h05A);
    take(9'h1A5);
    take(9'h05A);
    receive_interrupt_enable_i = 1'b1;
    receive_interrupt_priority_i = 1'b1;
    send(9'h100);
    chk("irq high", 9'h001, {8'h00, rx_irq_high_o});
    receive_interrupt_priority_i = 1'b0;
    tick();
    chk("irq low", 9'h001, {8'h00, rx_irq_low_o});
    take(9'h100);
    for (int i = 0; i < 9; i++) send(9'h0C0 + 9'(i));
    chk("overrun", 9'h001, {8'h00, rsc_o[1]});
    for (int i = 0; i < 8; i++) take(9'h0C0 + 9'(i));
    wr(1, 8'h00);
    chk("overrun clear", 9'h000, {8'h00, rsc_o[1]});
    wr(1, 8'hD8);
    send(9'h033);
    send(9'h1C3);
    take(9'h1C3);
    chk("address drop", 9'h000, {8'h00, receive_flag_o});
    wr(1, 8'hD0);
    send(9'h044);
    take(9'h044);
    wr(1, 8'h90);
    nine_bit_i = 1'b0;
    send(9'h096);
    take(9'h096);
    bang(8'h3C, 1'b0);
    chk("framing flag", 9'h001, {8'h00, rsc2[2]});
    chk("framing data", 9'h03C, {1'b0, rbuf2});
    pop();
    bang(8'h55, 1'b1);
    chk("clean stop", 9'h001, {rsc2[2], 7'h00, flag2});
    chk("clean data", 9'h055, {1'b0, rbuf2});
    pop();
    end_sim();
  end
endmodule : asrx_test
